// File: rtl/udw_host.sv
// Host controller that drives select and direction pins of the wiper device
`timescale 1ns/10ps
`default_nettype none
`include "udw_regs.svh"
module udw_host
(
  input  wire logic              clk_sys,   // System clock, 100 MHz
  input  wire logic              sys_rst,   // Async reset, active high
  input  wire logic              clk_link,  // Link clock for pin timing
  input  wire logic              cmd_valid, // Request a command
  input  wire udw_pkg::udw_cmd_e cmd_kind,  // Command variant
  input  wire logic [5:0]        cmd_steps, // Number of rising dir edges
  output logic                   cmd_ready, // Ready for a command
  output logic                   cmd_done,  // One-cycle pulse when done
  output logic                   sel_low,   // Select driven to input_low_level
  output logic                   sel_hv,    // Select to high_voltage_select_level
  output logic                   dir_out    // Direction pin level
);
  // Link-domain state
  udw_pkg::udw_s lk_q;
  udw_pkg::udw_s lk_d;
  // Request toggle and its capture in system domain
  logic          req_tgl_q;
  udw_pkg::udw_cmd_e kind_q;
  logic [5:0]    steps_q;
  logic          busy_q;
  // Crossings
  logic          req_s1_q;
  logic          req_s2_q;
  logic          done_s1_q;
  logic          done_s2_q;
  logic          done_s3_q;
  logic          req_seen_q;
  // Link reset, asserted at once and released on clk_link
  logic          rst_l1_q;   // First release stage
  logic          rst_l2_q;   // Reset seen by all other link flops

  // System side: launch request, hold fields stable until done
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      req_tgl_q <= 1'b0;
      kind_q    <= udw_pkg::UDW_CMD_INC;
      steps_q   <= 6'h00;
      busy_q    <= 1'b0;
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
      done_s3_q <= 1'b0;
    end
    else
    begin
      done_s1_q <= lk_q.done_tgl;
      done_s2_q <= done_s1_q;
      done_s3_q <= done_s2_q;
      if (cmd_valid && !busy_q)
      begin
        // New command immediately after idle return
        req_tgl_q <= ~req_tgl_q;
        kind_q    <= cmd_kind;
        steps_q   <= cmd_steps;
        busy_q    <= 1'b1;
      end
      else if (done_s2_q != done_s3_q)
      begin
        busy_q <= 1'b0;
      end
    end
  end

  assign cmd_ready = !busy_q;
  assign cmd_done  = done_s2_q != done_s3_q;

  // Link reset release: asserts with sys_rst, drops two link edges later
  // so no link flop leaves reset close to a link edge
  always_ff @(posedge clk_link or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rst_l1_q <= 1'b1;
      rst_l2_q <= 1'b1;
    end
    else
    begin
      rst_l1_q <= 1'b0;
      rst_l2_q <= rst_l1_q;
    end
  end

  // Link side request synchroniser
  always_ff @(posedge clk_link or posedge rst_l2_q)
  begin
    if (rst_l2_q)
    begin
      req_s1_q   <= 1'b0;
      req_s2_q   <= 1'b0;
      req_seen_q <= 1'b0;
    end
    else
    begin
      req_s1_q   <= req_tgl_q;
      req_s2_q   <= req_s1_q;
      req_seen_q <= req_s2_q;
    end
  end

  // Pin sequencer next state
  always_comb
  begin
    lk_d = lk_q;
    if (lk_q.tmr != 8'h00)
    begin
      // Hold each pin phase for the step time
      lk_d.tmr = lk_q.tmr - 8'h01;
    end
    else
    begin
      unique case (lk_q.st)
        udw_pkg::UDW_IDLE:
        begin
          // Select idle high ignores dir edges
          lk_d.sel_low = 1'b0;
          lk_d.sel_hv  = 1'b0;
          if (req_s2_q != req_seen_q)
          begin
            lk_d.cmd  = kind_q;
            lk_d.left = steps_q;
            // Direction level chooses up or down
            lk_d.dir  = (kind_q == udw_pkg::UDW_CMD_INC) ||
                        (kind_q == udw_pkg::UDW_CMD_INC_CMP) ||
                        (kind_q == udw_pkg::UDW_CMD_HV_INC1) ||
                        (kind_q == udw_pkg::UDW_CMD_HV_INC2);
            lk_d.st   = udw_pkg::UDW_SETUP;
            lk_d.tmr  = 8'(`UDW_STEP_CYC);
          end
        end
        udw_pkg::UDW_SETUP:
        begin
          // Low select is standard, high-voltage select the alternate set
          lk_d.sel_low = !lk_q.cmd[2];
          lk_d.sel_hv  = lk_q.cmd[2];
          lk_d.st      = udw_pkg::UDW_ENTER;
          lk_d.tmr     = 8'(`UDW_STEP_CYC);
        end
        udw_pkg::UDW_ENTER:
        begin
          // Drop dir so each step is a clean rising edge
          lk_d.dir = 1'b0;
          lk_d.st  = (lk_q.left == 6'h00) ? udw_pkg::UDW_EXIT : udw_pkg::UDW_LOW;
          lk_d.tmr = 8'(`UDW_STEP_CYC);
        end
        udw_pkg::UDW_LOW:
        begin
          // Rising edge moves the wiper one step
          lk_d.dir  = 1'b1;
          lk_d.left = lk_q.left - 6'h01;
          lk_d.st   = udw_pkg::UDW_HIGH;
          lk_d.tmr  = 8'(`UDW_STEP_CYC);
        end
        udw_pkg::UDW_HIGH:
        begin
          if (lk_q.left != 6'h00)
          begin
            lk_d.dir = 1'b0;
            lk_d.st  = udw_pkg::UDW_LOW;
          end
          else
          begin
            // Exit level of dir per variant, no rising edge here
            unique case (lk_q.cmd)
              udw_pkg::UDW_CMD_INC_CMP: lk_d.dir = 1'b0;
              udw_pkg::UDW_CMD_DEC:     lk_d.dir = 1'b0;
              udw_pkg::UDW_CMD_DEC_CMP: lk_d.dir = 1'b1;
              udw_pkg::UDW_CMD_HV_INC1: lk_d.dir = 1'b1;
              udw_pkg::UDW_CMD_HV_DEC2: lk_d.dir = 1'b1;
              udw_pkg::UDW_CMD_HV_INC2: lk_d.dir = 1'b0;
              udw_pkg::UDW_CMD_HV_DEC1: lk_d.dir = 1'b0;
              udw_pkg::UDW_CMD_INC:     lk_d.dir = 1'b1;
            endcase
            lk_d.st = udw_pkg::UDW_EXIT;
          end
          lk_d.tmr = 8'(`UDW_STEP_CYC);
        end
        udw_pkg::UDW_EXIT:
        begin
          // Return select to idle promptly after last step
          lk_d.sel_low  = 1'b0;
          lk_d.sel_hv   = 1'b0;
          lk_d.done_tgl = ~lk_q.done_tgl;
          lk_d.st       = udw_pkg::UDW_IDLE;
          lk_d.tmr      = 8'(`UDW_STEP_CYC);
        end
        default:
        begin
          // Corrupt one-hot code: release select and go idle
          lk_d.sel_low = 1'b0;
          lk_d.sel_hv  = 1'b0;
          lk_d.st      = udw_pkg::UDW_IDLE;
        end
      endcase
    end
    lk_d.busy = lk_d.st != udw_pkg::UDW_IDLE;
  end

  // Link state register
  always_ff @(posedge clk_link or posedge rst_l2_q)
  begin
    if (rst_l2_q)
    begin
      lk_q <= '{st: udw_pkg::UDW_IDLE, cmd: udw_pkg::UDW_CMD_INC, left: 6'h00,
                tmr: 8'h00, dir: 1'b0, sel_low: 1'b0, sel_hv: 1'b0,
                busy: 1'b0, done_tgl: 1'b0};
    end
    else
    begin
      lk_q <= lk_d;
    end
  end

  // Pin outputs straight from flip-flops
  assign sel_low = lk_q.sel_low;
  assign sel_hv  = lk_q.sel_hv;
  assign dir_out = lk_q.dir;
endmodule
`default_nettype wire

// File: rtl/udw_pkg.sv
// Types for the up/down wiper step host controller
package udw_pkg;
  // Command variant encodings
  typedef enum logic [2:0]
  {
    UDW_CMD_INC     = 3'h0,
    UDW_CMD_INC_CMP = 3'h1,
    UDW_CMD_DEC     = 3'h2,
    UDW_CMD_DEC_CMP = 3'h3,
    UDW_CMD_HV_INC1 = 3'h4,
    UDW_CMD_HV_INC2 = 3'h5,
    UDW_CMD_HV_DEC1 = 3'h6,
    UDW_CMD_HV_DEC2 = 3'h7
  } udw_cmd_e;
  // Host sequencer states, one-hot
  typedef enum logic [5:0]
  {
    UDW_IDLE  = 6'h01,
    UDW_SETUP = 6'h02,
    UDW_ENTER = 6'h04,
    UDW_LOW   = 6'h08,
    UDW_HIGH  = 6'h10,
    UDW_EXIT  = 6'h20
  } udw_state_e;
  // Link-domain sequencer state of the host
  typedef struct packed
  {
    udw_state_e  st;
    udw_cmd_e    cmd;
    logic [5:0]  left;
    logic [7:0]  tmr;
    logic        dir;
    logic        sel_low;
    logic        sel_hv;
    logic        busy;
    logic        done_tgl;
  } udw_s;
endpackage

// File: rtl/udw_regs.svh
// Constants for the up/down wiper step host controller
`ifndef UDW_REGS_SVH
`define UDW_REGS_SVH
`define UDW_WIPER_MAX      6'h3f
`define UDW_WIPER_MIN      6'h00
`define UDW_WIPER_DEFAULT  6'h1f
`define UDW_STEP_NS        40
`define UDW_STEP_CYC       (((`UDW_STEP_NS) * 100 + 999) / 1000)
`endif

// File: sim/testbench.sv
// Bench for the wiper host controller driving a wiper device model
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // Row packs kind, steps, wiper after and dir after
  typedef struct packed {
    udw_pkg::udw_cmd_e kind;
    logic [5:0]        steps;
    logic [5:0]        wiper;
    logic              dir;
  } udw_row_s;
  udw_row_s          rows [9] = '{16'h01c5, 16'h2efe, 16'h017f, 16'h42f4, 16'h7f81,
                                  16'h8209, 16'ha008, 16'hc104, 16'he281};
  logic              clk_sys = 1'b0, clk_link = 1'b0, sys_rst = 1'b1, por = 1'b0;
  logic              cmd_valid = 1'b0, cmd_ready, cmd_done, sel_low, sel_hv, dir_out;
  udw_pkg::udw_cmd_e cmd_kind = udw_pkg::UDW_CMD_INC;
  logic [5:0]        cmd_steps = 6'h00, wiper;
  int                fails = 0, comparisons = 0, cycles = 0, hv_n = 0;
  udw_host i_udw_host (.clk_sys, .sys_rst, .clk_link, .cmd_valid, .cmd_kind,
    .cmd_steps, .cmd_ready, .cmd_done, .sel_low, .sel_hv, .dir_out);
  udw_dev_model i_udw_dev_model (.por, .sel_low, .sel_hv, .dir_in(dir_out), .wiper);
  // Compare and count
  task check(input logic [5:0] seen, input logic [5:0] exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Issue one command, keep a rival request up for hold cycles, await done
  task run(input udw_pkg::udw_cmd_e k, input logic [5:0] n, input int hold);
    cmd_kind <= k;
    cmd_steps <= n;
    cmd_valid <= 1'b1;
    @(posedge clk_sys);
    cmd_kind <= udw_pkg::UDW_CMD_DEC;
    repeat (hold) @(posedge clk_sys);
    cmd_valid <= 1'b0;
    for (int t = 0; t < 1000 && cmd_done !== 1'b1; t++) @(posedge clk_sys);
    check(6'(cmd_done), 6'h01, "done");
  endtask
  // Counts and verdict
  task finish_test(input int extra);
    fails += extra;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Clocks; link edges offset so they never meet system edges
  always #5 clk_sys = ~clk_sys;
  initial #1.3 forever #3 clk_link = ~clk_link;
  // Count high-voltage entries
  always @(posedge sel_hv) hv_n++;
  // Hang guard
  always @(posedge clk_sys) if (++cycles == 20000) finish_test(1);
  initial
  begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    por <= 1'b1;
    @(posedge clk_sys);
    check(wiper, 6'h1f, "power-on wiper");
    // Table of all kinds, back to back
    foreach (rows[i])
    begin
      run(rows[i].kind, rows[i].steps, 0);
      check(wiper, rows[i].wiper, "wiper");
      check(6'({dir_out, sel_low, sel_hv}), 6'({rows[i].dir, 2'b00}), "exit pins");
      $display("row %0d ended", i);
    end
    check(6'(hv_n), 6'h04, "hv entries");
    // Request while busy must be ignored
    run(udw_pkg::UDW_CMD_INC, 6'h01, 10);
    repeat (100) @(posedge clk_sys);
    check(wiper, 6'h01, "busy request");
    $display("refusal ended");
    // Reset mid-command with supply drop, then a fresh command
    cmd_kind <= udw_pkg::UDW_CMD_HV_INC1;
    cmd_steps <= 6'h3f;
    cmd_valid <= 1'b1;
    repeat (40) @(posedge clk_sys);
    sys_rst <= 1'b1;
    cmd_valid <= 1'b0;
    por <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check(6'({sel_low, sel_hv, dir_out, cmd_ready}), 6'h01, "reset pins");
    sys_rst <= 1'b0;
    por <= 1'b1;
    @(posedge clk_sys);
    check(wiper, 6'h1f, "reload");
    run(udw_pkg::UDW_CMD_DEC, 6'h02, 0);
    check(wiper, 6'h1d, "after reset");
    $display("reset ended");
    finish_test(0);
  end
endmodule
`default_nettype wire

// File: sim/udw_dev_model.sv
// Behavioural wiper device seen through the select and direction pins
`timescale 1ns/10ps
`default_nettype none
module udw_dev_model
(
  input  wire logic  por,     // Supply rises through trip point
  input  wire logic  sel_low, // Select at input_low_level
  input  wire logic  sel_hv,  // Select at high_voltage_select_level
  input  wire logic  dir_in,  // Direction pin
  output logic [5:0] wiper    // Bench view only, host never reads it
);
  logic up; // Mode latched at entry
  // Direction level as select leaves idle picks the mode
  always @(posedge sel_low or posedge sel_hv)
    up = dir_in;
  // Supply recovery reloads mid-scale
  always @(posedge por) wiper = 6'h1f;
  // Direction rises step only while selected, clamped at both ends
  always @(posedge dir_in)
    if (sel_low || sel_hv)
      wiper = up ? wiper + 6'(wiper != 6'h3f) : wiper - 6'(wiper != 6'h00);
endmodule
`default_nettype wire

// File: sim/udw_host_asserts.sv
// Checker for the wiper host handshake and pin sequencing
`timescale 1ns/10ps
`default_nettype none
module udw_host_asserts
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_link,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic cmd_done,
  input wire logic sel_low,
  input wire logic sel_hv,
  input wire logic dir_out
);
  wire sel_any = sel_low | sel_hv; // Select away from idle
  chk_take_busy: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cmd_valid && cmd_ready |=> !cmd_ready) else $error("take left ready");
  chk_done_pulse: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cmd_done |=> cmd_ready && !cmd_done) else $error("bad done pulse");
  chk_done_bound: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cmd_valid && cmd_ready |-> ##[2:1000] cmd_done) else $error("done late");
  chk_idle_pins: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cmd_ready |-> !sel_any) else $error("select off idle");
  chk_sel_excl: assert property (@(posedge clk_link) disable iff (sys_rst)
    !(sel_low && sel_hv)) else $error("two select levels");
  chk_entry_dir: assert property (@(posedge clk_link) disable iff (sys_rst)
    $rose(sel_any) |-> $stable(dir_out)) else $error("dir moved at entry");
  chk_exit_dir: assert property (@(posedge clk_link) disable iff (sys_rst)
    $fell(sel_any) |-> $stable(dir_out)) else $error("dir moved at exit");
  chk_step_width: assert property (@(posedge clk_link) disable iff (sys_rst)
    $rose(dir_out) && sel_any |=> dir_out [*4]) else $error("step too short");
  // Main scenarios reached
  cover property (@(posedge clk_sys) cmd_done);
  cover property (@(posedge clk_link) $rose(sel_hv));
  cover property (@(posedge clk_sys) cmd_valid && !cmd_ready);
endmodule
bind udw_host udw_host_asserts i_udw_host_asserts (.clk_sys, .sys_rst, .clk_link,
  .cmd_valid, .cmd_ready, .cmd_done, .sel_low, .sel_hv, .dir_out);
`default_nettype wire
